/* File: hw/prm_clock_control.sv */
// Operation
// - bit 14 halves interrupt controller clock
// - bit 13 lets processor clock run in reset
// - bit 12 picks timer clock source
// - bits 11:10 divide clock two for MMU
// - bits 9:8 divide clock three for traffic
// - bits 7:6 divide clock two for processor
// - bits 5:4 divide clock one for core
// - bits 3:2 divide clock three for display
// - bits 1:0 divide clock one for peripherals
// - ten RW registers, offsets 0x00 to 0x24
`timescale 1ns/1ps
`include "prm_regs.svh"

module prm_clock_control
   import prm_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rstn,
   input  wire logic        reg_sel,
   input  wire logic        reg_wr,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   output logic      [31:0] reg_rdata,
   input  wire logic        input_reference_clock,
   input  wire logic        generated_clock_one,
   input  wire logic        generated_clock_two,
   input  wire logic        generated_clock_three,
   input  wire logic        sigproc_in_reset,
   output logic             main_core_clock,
   output logic             irq_ctrl_clock,
   output logic             sigproc_core_clock,
   output logic             sigproc_mmu_clock,
   output logic             traffic_ctrl_clock,
   output logic             display_ctrl_clock,
   output logic             ext_peripheral_clock,
   output logic             main_timer_clock
);

   localparam int NREG = int'(`PRM_REG_COUNT);

   logic [31:0] regs [0:NREG-1];

   wire  [3:0]  reg_index;
   wire         reg_hit;
   wire         reg_write;
   wire  [31:0] read_value;
   wire  [31:0] ctl;

   wire              irq_ctrl_clock_half_select;
   wire              sigproc_clock_in_reset_enable;
   wire              timer_clock_source_select;
   wire prm_div_type sigproc_mmu_divider;
   wire prm_div_type traffic_ctrl_divider;
   wire prm_div_type sigproc_core_divider;
   wire prm_div_type main_core_divider;
   wire prm_div_type display_ctrl_divider;
   wire prm_div_type ext_peripheral_divider;
   wire prm_div_type irq_divider;
   wire              sigproc_run;
   wire              next_main_timer_clock;

   // Word-aligned decode of the ten registers
   assign reg_index = reg_addr[`PRM_REG_INDEX_MSB:`PRM_REG_INDEX_LSB];
   assign reg_hit   = (reg_addr[1:0] == `PRM_ADDR_LOW_ZERO)
                    & (reg_addr[7:6] == `PRM_ADDR_HIGH_ZERO)
                    & (reg_index < `PRM_REG_COUNT);
   assign reg_write = reg_sel & reg_wr & reg_hit;
   assign read_value = reg_hit ? regs[reg_index] : `PRM_READ_UNMAPPED;

   // Register storage, full 32-bit writes
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < NREG; i++) begin
            regs[i] <= `PRM_RST_OTHER;
         end
         regs[0] <= `PRM_RST_CLOCK_PRESCALER_CONTROL;
      end else if (reg_write) begin
         regs[reg_index] <= reg_wdata;
      end
   end

   // Read data registered, one cycle after the read strobe
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= `PRM_READ_UNMAPPED;
      end else if (reg_sel & ~reg_wr) begin
         reg_rdata <= read_value;
      end
   end

   // Field extraction; upper reserved bits feed nothing
   assign ctl = regs[0];
   assign irq_ctrl_clock_half_select    = ctl[`PRM_BIT_IRQ_HALF];
   assign sigproc_clock_in_reset_enable = ctl[`PRM_BIT_SIGPROC_IN_RST];
   assign timer_clock_source_select     = ctl[`PRM_BIT_TIMER_SRC];
   assign sigproc_mmu_divider    = prm_div_type'(ctl[`PRM_FLD_SIGPROC_MMU]);
   assign traffic_ctrl_divider   = prm_div_type'(ctl[`PRM_FLD_TRAFFIC]);
   assign sigproc_core_divider   = prm_div_type'(ctl[`PRM_FLD_SIGPROC_CORE]);
   assign main_core_divider      = prm_div_type'(ctl[`PRM_FLD_MAIN_CORE]);
   assign display_ctrl_divider   = prm_div_type'(ctl[`PRM_FLD_DISPLAY]);
   assign ext_peripheral_divider = prm_div_type'(ctl[`PRM_FLD_EXT_PERIPH]);

   // Interrupt controller runs at core rate or half of it
   assign irq_divider = irq_ctrl_clock_half_select ? PRM_DIV2
                                                   : PRM_DIV1;

   // Processor clock held off in reset unless enabled
   assign sigproc_run = ~sigproc_in_reset
                      | sigproc_clock_in_reset_enable;

   // Timer source mux
   assign next_main_timer_clock = timer_clock_source_select
                                ? generated_clock_one
                                : input_reference_clock;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         main_timer_clock <= 1'b0;
      end else begin
         main_timer_clock <= next_main_timer_clock;
      end
   end

   // Domain prescalers
   prm_prescaler u_mmu (
      .clock   (clock),
      .rstn    (rstn),
      .src_en  (generated_clock_two),
      .run     (sigproc_run),
      .div_sel (sigproc_mmu_divider),
      .out_en  (sigproc_mmu_clock)
   );

   prm_prescaler u_traffic (
      .clock   (clock),
      .rstn    (rstn),
      .src_en  (generated_clock_three),
      .run     (1'b1),
      .div_sel (traffic_ctrl_divider),
      .out_en  (traffic_ctrl_clock)
   );

   prm_prescaler u_sigproc (
      .clock   (clock),
      .rstn    (rstn),
      .src_en  (generated_clock_two),
      .run     (sigproc_run),
      .div_sel (sigproc_core_divider),
      .out_en  (sigproc_core_clock)
   );

   prm_prescaler u_main (
      .clock   (clock),
      .rstn    (rstn),
      .src_en  (generated_clock_one),
      .run     (1'b1),
      .div_sel (main_core_divider),
      .out_en  (main_core_clock)
   );

   prm_prescaler u_display (
      .clock   (clock),
      .rstn    (rstn),
      .src_en  (generated_clock_three),
      .run     (1'b1),
      .div_sel (display_ctrl_divider),
      .out_en  (display_ctrl_clock)
   );

   prm_prescaler u_periph (
      .clock   (clock),
      .rstn    (rstn),
      .src_en  (generated_clock_one),
      .run     (1'b1),
      .div_sel (ext_peripheral_divider),
      .out_en  (ext_peripheral_clock)
   );

   prm_prescaler u_irq (
      .clock   (clock),
      .rstn    (rstn),
      .src_en  (main_core_clock),
      .run     (1'b1),
      .div_sel (irq_divider),
      .out_en  (irq_ctrl_clock)
   );

endmodule : prm_clock_control

/* File: hw/prm_pkg.sv */
package prm_pkg;

   // Prescaler ratio encoding
   typedef enum logic [1:0] {
      PRM_DIV1 = 2'h0,
      PRM_DIV2 = 2'h1,
      PRM_DIV4 = 2'h2,
      PRM_DIV8 = 2'h3
   } prm_div_type;

endpackage : prm_pkg

/* File: hw/prm_prescaler.sv */
`timescale 1ns/1ps

module prm_prescaler
   import prm_pkg::*;
#(
   parameter int CW = 3
) (
   input  wire logic        clock,
   input  wire logic        rstn,
   input  wire logic        src_en,
   input  wire logic        run,
   input  wire prm_div_type div_sel,
   output logic             out_en
);

   logic [CW-1:0] count;
   logic [CW-1:0] mask;
   wire           hit;

   // Low count bits that must be zero for a pass-through
   always_comb begin
      case (div_sel)
         PRM_DIV1: mask = CW'(0);
         PRM_DIV2: mask = CW'(1);
         PRM_DIV4: mask = CW'(3);
         PRM_DIV8: mask = CW'(7);
         default:  mask = CW'(0);
      endcase
   end

   assign hit = ((count & mask) == CW'(0));

   // Count source pulses, pass one of every 1, 2, 4 or 8
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         count  <= '0;
         out_en <= 1'b0;
      end else begin
         out_en <= src_en & run & hit;
         if (src_en) begin
            count <= count + CW'(1);
         end
      end
   end

endmodule : prm_prescaler

/* File: hw/prm_regs.svh */
`ifndef PRM_REGS_SVH
`define PRM_REGS_SVH

// Register byte offsets
`define PRM_OFS_CLOCK_PRESCALER_CONTROL   8'h00
`define PRM_OFS_IDLE_ENABLE_CONTROL_ONE   8'h04
`define PRM_OFS_IDLE_ENABLE_CONTROL_TWO   8'h08
`define PRM_OFS_RESTORE_POWER_DELAY       8'h0C
`define PRM_OFS_MASTER_SOFTWARE_RESET     8'h10
`define PRM_OFS_PERIPHERAL_RESET_CONTROL  8'h14
`define PRM_OFS_CLOCK_RESET_STATUS        8'h18
`define PRM_OFS_CLOCK_OUTPUT_DEFINITION   8'h1C
`define PRM_OFS_CLOCK_OUTPUT_RESERVED     8'h20
`define PRM_OFS_IDLE_ENABLE_CONTROL_THREE 8'h24

// Register bank geometry
`define PRM_REG_COUNT       4'hA
`define PRM_REG_INDEX_LSB   2
`define PRM_REG_INDEX_MSB   5
`define PRM_ADDR_LOW_ZERO   2'h0
`define PRM_ADDR_HIGH_ZERO  2'h0

// Reset values
`define PRM_RST_CLOCK_PRESCALER_CONTROL 32'h0000_3000
`define PRM_RST_OTHER                   32'h0000_0000
`define PRM_READ_UNMAPPED               32'h0000_0000

// Clock prescaler control field positions
`define PRM_BIT_IRQ_HALF        14
`define PRM_BIT_SIGPROC_IN_RST  13
`define PRM_BIT_TIMER_SRC       12
`define PRM_FLD_SIGPROC_MMU     11:10
`define PRM_FLD_TRAFFIC         9:8
`define PRM_FLD_SIGPROC_CORE    7:6
`define PRM_FLD_MAIN_CORE       5:4
`define PRM_FLD_DISPLAY         3:2
`define PRM_FLD_EXT_PERIPH      1:0

`endif

/* File: tb/prm_clock_control_properties.sv */
`timescale 1ns/1ps
module prm_clock_control_properties (
   input wire logic clock,
   input wire logic rstn,
   input wire logic input_reference_clock,
   input wire logic generated_clock_one,
   input wire logic generated_clock_two,
   input wire logic generated_clock_three,
   input wire logic main_core_clock,
   input wire logic irq_ctrl_clock,
   input wire logic sigproc_core_clock,
   input wire logic sigproc_mmu_clock,
   input wire logic traffic_ctrl_clock,
   input wire logic display_ctrl_clock,
   input wire logic ext_peripheral_clock,
   input wire logic main_timer_clock
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   // Every divided pulse follows a source pulse one cycle earlier
   a_core_from_one: assert property (
      main_core_clock |-> $past(generated_clock_one))
      else $error("core clock without source pulse");
   a_irq_from_core: assert property (
      irq_ctrl_clock |-> $past(main_core_clock))
      else $error("irq clock without core pulse");
   a_proc_from_two: assert property (
      sigproc_core_clock |-> $past(generated_clock_two))
      else $error("processor clock without source pulse");
   a_mmu_from_two: assert property (
      sigproc_mmu_clock |-> $past(generated_clock_two))
      else $error("mmu clock without source pulse");
   a_traffic_from_three: assert property (
      traffic_ctrl_clock |-> $past(generated_clock_three))
      else $error("traffic clock without source pulse");
   a_display_from_three: assert property (
      display_ctrl_clock |-> $past(generated_clock_three))
      else $error("display clock without source pulse");
   a_periph_from_one: assert property (
      ext_peripheral_clock |-> $past(generated_clock_one))
      else $error("peripheral clock without source pulse");
   a_timer_from_src: assert property (
      main_timer_clock
      |-> $past(generated_clock_one || input_reference_clock))
      else $error("timer clock without source pulse");
endmodule : prm_clock_control_properties

bind prm_clock_control prm_clock_control_properties u_props (
   .clock(clock), .rstn(rstn), .input_reference_clock(input_reference_clock),
   .generated_clock_one(generated_clock_one),
   .generated_clock_two(generated_clock_two),
   .generated_clock_three(generated_clock_three),
   .main_core_clock(main_core_clock), .irq_ctrl_clock(irq_ctrl_clock),
   .sigproc_core_clock(sigproc_core_clock),
   .sigproc_mmu_clock(sigproc_mmu_clock),
   .traffic_ctrl_clock(traffic_ctrl_clock),
   .display_ctrl_clock(display_ctrl_clock),
   .ext_peripheral_clock(ext_peripheral_clock),
   .main_timer_clock(main_timer_clock));

/* File: tb/prm_clock_control_tb.sv */
`timescale 1ns/1ps
module prm_clock_control_tb;
   logic        clock = 0, rstn = 0, reg_sel = 0, reg_wr = 0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic        ref_ck = 0, g1 = 0, g2 = 0, g3 = 0, in_rst = 0;
   wire  [7:0]  outs;
   logic [31:0] cnt [8];
   int          err_count = 0, n_tests = 0;

   prm_clock_control dut (.clock(clock), .rstn(rstn), .reg_sel(reg_sel),
      .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .input_reference_clock(ref_ck),
      .generated_clock_one(g1), .generated_clock_two(g2),
      .generated_clock_three(g3), .sigproc_in_reset(in_rst),
      .main_core_clock(outs[7]), .irq_ctrl_clock(outs[6]),
      .sigproc_core_clock(outs[5]), .sigproc_mmu_clock(outs[4]),
      .traffic_ctrl_clock(outs[3]), .display_ctrl_clock(outs[2]),
      .ext_peripheral_clock(outs[1]), .main_timer_clock(outs[0]));

   // Clock and pulse counters
   initial forever #25 clock = ~clock;
   always @(posedge clock)
      for (int i = 0; i < 8; i++) if (outs[i] === 1'b1) cnt[i] <= cnt[i] + 1;

   task automatic wrap_up();
      $display("Checks %0d, errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : wrap_up

   task automatic chk(input string nm, input logic [31:0] exp, got);
      n_tests++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", nm, exp, got);
         err_count++;
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      #1 reg_sel = 1;
      reg_wr = 1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clock);
      #1 reg_sel = 0;
      reg_wr = 0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock);
      #1 reg_sel = 1;
      reg_wr = 0;
      reg_addr = a;
      @(posedge clock);
      #1 reg_sel = 0;
      chk("rdata", exp, reg_rdata);
   endtask : rd

   // Program the prescaler, run 64 source pulses, count the outputs
   task automatic win(input logic [31:0] c, input logic ir);
      logic gate;
      gate = ir & ~c[13];
      wr(8'h00, c);
      rd(8'h00, c);
      in_rst = ir;
      for (int i = 0; i < 8; i++) cnt[i] = 0;
      for (int k = 0; k < 64; k++) begin
         @(posedge clock); #1 g1 = 1; g2 = 1; g3 = 1; ref_ck = k[0];
      end
      @(posedge clock); #1 g1 = 0; g2 = 0; g3 = 0; ref_ck = 0;
      repeat (4) @(posedge clock);
      #1 chk("core", 64 >> c[5:4], cnt[7]);
      chk("irq", (64 >> c[5:4]) >> c[14], cnt[6]);
      chk("proc", gate ? 0 : 64 >> c[7:6], cnt[5]);
      chk("mmu", gate ? 0 : 64 >> c[11:10], cnt[4]);
      chk("traffic", 64 >> c[9:8], cnt[3]);
      chk("display", 64 >> c[3:2], cnt[2]);
      chk("periph", 64 >> c[1:0], cnt[1]);
      chk("timer", c[12] ? 64 : 32, cnt[0]);
   endtask : win

   initial begin
      logic [1:0] dd;
      repeat (8) @(posedge clock);
      #1 rstn = 1;
      rd(8'h00, 32'h0000_3000);
      for (int i = 1; i < 10; i++) rd(8'(i * 4), 32'h0);
      // Full 32-bit word writes, as the main core issues them
      for (int i = 0; i < 10; i++) begin
         wr(8'(i * 4), 32'hA5A5_0000 | i);
      end
      for (int i = 0; i < 10; i++) rd(8'(i * 4), 32'hA5A5_0000 | i);
      wr(8'h28, 32'hFFFF_FFFF);
      wr(8'h05, 32'h0);
      rd(8'h28, 32'h0);
      rd(8'h04, 32'hA5A5_0001);
      for (int d = 0; d < 4; d++) begin
         dd = d[1:0];
         win({17'h1FFFF, dd[0], dd[1], dd[0], dd, dd + 2'h1, dd + 2'h2,
              dd + 2'h3, dd, dd + 2'h1}, dd[0]);
      end
      @(posedge clock);
      #1 rstn = 0;
      @(posedge clock);
      #1 rstn = 1;
      rd(8'h00, 32'h0000_3000);
      wrap_up();
   end

   // Watchdog
   initial begin
      #100000;
      err_count++;
      wrap_up();
   end
endmodule : prm_clock_control_tb
